// ---- i2cs_defs.vh ----
// Constants for the two-wire slave bus-condition block
`ifndef I2CS_DEFS_VH
`define I2CS_DEFS_VH
`define I2CS_CLK_HZ 25000000
`define I2CS_LONG_HOLD_NS 300
`define I2CS_LONG_HOLD_CYC ((`I2CS_LONG_HOLD_NS * (`I2CS_CLK_HZ / 1000000) + 999) / 1000)
`define I2CS_SHORT_HOLD_CYC 1
`define I2CS_HOLD_W 4
`define I2CS_TEN_BIT_HI 5'h1e
`define I2CS_MODE_7 2'h0
`define I2CS_MODE_10 2'h1
`define I2CS_MODE_7_SP 2'h2
`define I2CS_MODE_10_SP 2'h3
`define I2CS_BIT_W 4
`define I2CS_ACK_BIT 4'h8
`endif

// ---- i2cs_sync.v ----
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps
`default_nettype none
module i2cs_sync
(
	input wire clk_i,
	input wire rst_b_i,
	input wire line_i,
	output reg level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_reg;
	reg prev_reg;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_reg <= 1'b1;
			level_o <= 1'b1;
			prev_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= line_i;
			level_o <= meta_reg;
			prev_reg <= level_o;
		end
	end
	assign rise_o = level_o & ~prev_reg;
	assign fall_o = ~level_o & prev_reg;
endmodule // i2cs_sync
`default_nettype wire

// ---- i2cs_hold.v ----
// SDA hold-time counter started on each falling SCL edge
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defs.vh"
module i2cs_hold
(
	input wire clk_i,
	input wire rst_b_i,
	input wire start_i,
	input wire long_i,
	output wire busy_o
);
	localparam [31:0] HOLD_LONG = `I2CS_LONG_HOLD_CYC;
	localparam [31:0] HOLD_SHORT = `I2CS_SHORT_HOLD_CYC;
	reg [`I2CS_HOLD_W-1:0] cnt_reg;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cnt_reg <= {`I2CS_HOLD_W{1'b0}};
		else if (start_i)
			cnt_reg <= long_i ? HOLD_LONG[`I2CS_HOLD_W-1:0] : HOLD_SHORT[`I2CS_HOLD_W-1:0];
		else if (cnt_reg != {`I2CS_HOLD_W{1'b0}})
			cnt_reg <= cnt_reg - 1'b1;
	end
	assign busy_o = start_i | (cnt_reg != {`I2CS_HOLD_W{1'b0}});
endmodule // i2cs_hold
`default_nettype wire

// ---- i2cs_core.v ----
// Two-wire slave: bus conditions, address match and acknowledge slot
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defs.vh"
module i2cs_core
(
	input wire clk_i,
	input wire rst_b_i,
	input wire scl_i,
	input wire sda_i,
	output reg scl_oe_b_o,
	output reg sda_oe_b_o,
	output reg scl_o,
	output reg sda_o,
	input wire [1:0] slave_mode_select_i,
	input wire [7:0] own_address_i,
	input wire [7:0] address_mask_i,
	input wire long_hold_select_i,
	input wire start_irq_enable_i,
	input wire stop_irq_enable_i,
	input wire address_hold_enable_i,
	input wire data_hold_enable_i,
	input wire ack_response_value_i,
	input wire clock_release_i,
	input wire [7:0] tx_data_i,
	input wire buffer_full_flag_i,
	input wire receive_overflow_flag_i,
	output reg [7:0] receive_buffer_o,
	output reg rx_load_o,
	output reg port_irq_o,
	output reg ack_result_bit_o,
	output reg ack_time_flag_o,
	output reg start_seen_o,
	output reg stop_seen_o,
	output reg read_not_write_o,
	output reg collision_o,
	output reg bus_idle_o
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_LOW = 3'h2;
	localparam ST_RX = 3'h3;
	localparam ST_TX = 3'h4;
	localparam ST_SKIP = 3'h5;

	//////////////////////////////////////////////////////////////////////
	// Line sampling
	wire scl_s;
	wire sda_s;
	wire scl_rise;
	wire scl_fall;
	wire sda_rise;
	wire sda_fall;
	i2cs_sync u_scl
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.line_i(scl_i),
		.level_o(scl_s),
		.rise_o(scl_rise),
		.fall_o(scl_fall)
	);
	i2cs_sync u_sda
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.line_i(sda_i),
		.level_o(sda_s),
		.rise_o(sda_rise),
		.fall_o(sda_fall)
	);
	wire hold_busy;
	i2cs_hold u_hold
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.start_i(scl_fall),
		.long_i(long_hold_select_i),
		.busy_o(hold_busy)
	);

	//////////////////////////////////////////////////////////////////////
	// Bus conditions
	reg active_reg;
	reg low_seen_reg;
	wire start_det = sda_fall & scl_s;
	wire stop_det = sda_rise & scl_s & low_seen_reg;
	wire restart_det = start_det & active_reg & low_seen_reg;
	wire ten_bit = slave_mode_select_i[0];
	wire sp_mode = slave_mode_select_i[1];
	wire start_irq = sp_mode | start_irq_enable_i;
	wire stop_irq = sp_mode | stop_irq_enable_i;

	//////////////////////////////////////////////////////////////////////
	// Slave state
	reg [2:0] state_reg;
	reg [`I2CS_BIT_W-1:0] bit_reg;
	reg [7:0] shift_reg;
	reg [7:0] tx_reg;
	reg first_reg;
	reg hi_match_reg;
	reg full_match_reg;
	reg stretch_reg;
	reg ack_drive_reg;
	reg nack_reg;
	reg drv_sda_reg;

	// Masked compare; mask bit 0 means don't care
	wire [7:0] cmp_mask = address_mask_i;
	wire match7 = ((shift_reg[7:1] ^ own_address_i[7:1]) & cmp_mask[7:1]) == 7'h00;
	wire match10h = (shift_reg[7:3] == `I2CS_TEN_BIT_HI)
		&& (((shift_reg[2:1] ^ own_address_i[2:1]) & cmp_mask[2:1]) == 2'h0);
	wire match10l = ((shift_reg ^ own_address_i) & cmp_mask) == 8'h00;
	wire holds = address_hold_enable_i | data_hold_enable_i;
	wire byte_done = (bit_reg == `I2CS_ACK_BIT);
	// First address byte accepted or refused
	wire first_ok = (!ten_bit && match7)
		|| (ten_bit && match10h && (!shift_reg[0] || full_match_reg));
	wire addr_fail = (state_reg == ST_ADDR) && first_reg && !first_ok;
	// Ten-bit low address byte that missed
	wire lo_miss = (state_reg == ST_ADDR) && !first_reg && hi_match_reg && !match10l;

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= ST_IDLE;
			active_reg <= 1'b0;
			low_seen_reg <= 1'b0;
			bit_reg <= {`I2CS_BIT_W{1'b0}};
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			first_reg <= 1'b0;
			hi_match_reg <= 1'b0;
			full_match_reg <= 1'b0;
			stretch_reg <= 1'b0;
			ack_drive_reg <= 1'b0;
			nack_reg <= 1'b0;
			drv_sda_reg <= 1'b1;
			receive_buffer_o <= 8'h00;
			rx_load_o <= 1'b0;
			port_irq_o <= 1'b0;
			ack_result_bit_o <= 1'b0;
			ack_time_flag_o <= 1'b0;
			start_seen_o <= 1'b0;
			stop_seen_o <= 1'b0;
			read_not_write_o <= 1'b0;
			collision_o <= 1'b0;
			bus_idle_o <= 1'b1;
			scl_oe_b_o <= 1'b1;
			sda_oe_b_o <= 1'b1;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
		else
		begin
			rx_load_o <= 1'b0;
			port_irq_o <= 1'b0;
			collision_o <= 1'b0;
			start_seen_o <= 1'b0;
			stop_seen_o <= 1'b0;
			if (!scl_s)
				low_seen_reg <= 1'b1;
			if (clock_release_i)
				stretch_reg <= 1'b0;
			if (start_det)
			begin
				active_reg <= 1'b1;
				low_seen_reg <= 1'b0;
				state_reg <= ST_ADDR;
				// Start's own SCL fall wraps the count to zero
				bit_reg <= {`I2CS_BIT_W{1'b1}};
				first_reg <= 1'b1;
				stretch_reg <= 1'b0;
				ack_drive_reg <= 1'b0;
				drv_sda_reg <= 1'b1;
				ack_time_flag_o <= 1'b0;
				start_seen_o <= 1'b1;
				port_irq_o <= start_irq;
				if (!restart_det)
					full_match_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				active_reg <= 1'b0;
				low_seen_reg <= 1'b0;
				state_reg <= ST_IDLE;
				full_match_reg <= 1'b0;
				stretch_reg <= 1'b0;
				ack_drive_reg <= 1'b0;
				drv_sda_reg <= 1'b1;
				ack_time_flag_o <= 1'b0;
				stop_seen_o <= 1'b1;
				port_irq_o <= stop_irq;
			end
			else if (state_reg != ST_IDLE && state_reg != ST_SKIP)
			begin
				if (scl_rise)
				begin
					if (byte_done)
					begin
						if (state_reg == ST_TX)
							ack_result_bit_o <= sda_s;
					end
					else
					begin
						shift_reg <= {shift_reg[6:0], sda_s};
						if (state_reg == ST_TX && drv_sda_reg && !sda_s)
						begin
							collision_o <= 1'b1;
							state_reg <= ST_SKIP;
							drv_sda_reg <= 1'b1;
						end
					end
				end
				if (scl_fall)
				begin
					if (byte_done)
					begin
						bit_reg <= {`I2CS_BIT_W{1'b0}};
						ack_drive_reg <= 1'b0;
						ack_time_flag_o <= 1'b0;
						if (state_reg == ST_TX && ack_result_bit_o)
							state_reg <= ST_SKIP; // Master ended the read
						else if (state_reg == ST_TX || read_not_write_o && state_reg == ST_RX)
						begin
							state_reg <= ST_TX;
							tx_reg <= tx_data_i;
							stretch_reg <= 1'b1;
							port_irq_o <= 1'b1;
						end
						else if (state_reg == ST_ADDR && nack_reg)
							state_reg <= ST_SKIP;
					end
					else
						bit_reg <= bit_reg + 1'b1;
					if (bit_reg == `I2CS_ACK_BIT - 1'b1)
					begin
						// Eighth falling edge: decide on this byte
						if (state_reg == ST_TX)
							ack_drive_reg <= 1'b0;
						else if (state_reg == ST_ADDR && first_reg)
						begin
							first_reg <= 1'b0;
							if (!ten_bit && match7 || ten_bit && match10h && !shift_reg[0])
							begin
								hi_match_reg <= 1'b1;
								read_not_write_o <= ~ten_bit & shift_reg[0];
								state_reg <= ten_bit ? ST_ADDR : ST_RX;
								receive_buffer_o <= shift_reg;
								rx_load_o <= 1'b1;
								port_irq_o <= 1'b1;
							end
							else if (ten_bit && match10h && shift_reg[0] && full_match_reg)
							begin
								read_not_write_o <= 1'b1;
								state_reg <= ST_RX;
								receive_buffer_o <= shift_reg;
								rx_load_o <= 1'b1;
								port_irq_o <= 1'b1;
							end
							else
								state_reg <= ST_SKIP;
						end
						else if (state_reg == ST_ADDR && hi_match_reg)
						begin
							hi_match_reg <= 1'b0;
							full_match_reg <= match10l;
							read_not_write_o <= 1'b0;
							receive_buffer_o <= shift_reg;
							rx_load_o <= 1'b1;
							port_irq_o <= 1'b1;
							if (match10l)
								state_reg <= ST_RX;
							else
								nack_reg <= 1'b1;
						end
						else
						begin
							receive_buffer_o <= shift_reg;
							rx_load_o <= 1'b1;
							port_irq_o <= 1'b1;
						end
						if (state_reg != ST_TX && !addr_fail)
						begin
							nack_reg <= buffer_full_flag_i | receive_overflow_flag_i | lo_miss;
							ack_drive_reg <= 1'b1;
							ack_time_flag_o <= holds;
							stretch_reg <= holds;
						end
					end
				end
			end
			if (state_reg == ST_SKIP || !active_reg)
				ack_drive_reg <= 1'b0;
			// SDA drive updated only after the hold window
			if (!hold_busy && !scl_s)
			begin
				if (ack_drive_reg)
					drv_sda_reg <= holds ? ack_response_value_i : nack_reg;
				else if (state_reg == ST_TX && !byte_done)
					drv_sda_reg <= tx_reg[3'h7 - bit_reg[2:0]];
				else
					drv_sda_reg <= 1'b1;
			end
			sda_oe_b_o <= drv_sda_reg;
			scl_oe_b_o <= ~stretch_reg;
			bus_idle_o <= ~active_reg & scl_s & sda_s;
		end
	end
endmodule // i2cs_core
`default_nettype wire

// ---- i2cs_props.sv ----
// Concurrent checks on the two-wire slave ports
`timescale 1ns/1ps
`default_nettype none
module i2cs_props
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_oe_b_o,
	input wire logic sda_oe_b_o,
	input wire logic [1:0] slave_mode_select_i,
	input wire logic start_irq_enable_i,
	input wire logic address_hold_enable_i,
	input wire logic data_hold_enable_i,
	input wire logic rx_load_o,
	input wire logic port_irq_o,
	input wire logic ack_time_flag_o,
	input wire logic start_seen_o,
	input wire logic stop_seen_o,
	input wire logic bus_idle_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_irq_soon;
		##[0:2] port_irq_o;
	endsequence
	sequence s_irq_quiet;
		!port_irq_o [*3];
	endsequence
	a_start_lines: assert property (start_seen_o |-> scl_i && !sda_i)
		else $error("start pulse without start on lines");
	a_stop_lines: assert property (stop_seen_o |-> scl_i && sda_i)
		else $error("stop pulse without stop on lines");
	a_start_busy: assert property (start_seen_o |-> ##[0:2] !bus_idle_o)
		else $error("bus idle after start");
	a_stop_idle: assert property (stop_seen_o |-> ##[0:2] bus_idle_o)
		else $error("bus not idle after stop");
	a_no_both: assert property (!(start_seen_o && stop_seen_o))
		else $error("start and stop together");
	a_sda_drive_low: assert property ($fell(sda_oe_b_o) |-> !$past(scl_i, 2))
		else $error("slave drove data while clock high");
	a_stretch_low: assert property ($fell(scl_oe_b_o) |-> !$past(scl_i, 2))
		else $error("stretch begun while clock high");
	a_ack_time_holds: assert property (ack_time_flag_o |->
		address_hold_enable_i || data_hold_enable_i)
		else $error("ack time flag without hold enable");
	a_load_irq: assert property (rx_load_o |-> s_irq_soon)
		else $error("buffer load without interrupt");
	a_start_irq: assert property (start_seen_o && (slave_mode_select_i[1] ||
		start_irq_enable_i) |-> s_irq_soon)
		else $error("no interrupt on start");
	a_start_quiet: assert property (start_seen_o && !slave_mode_select_i[1] &&
		!start_irq_enable_i |-> s_irq_quiet)
		else $error("interrupt on start while disabled");
endmodule // i2cs_props
bind i2cs_core i2cs_props i2cs_props_i
(
	.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
	.scl_oe_b_o(scl_oe_b_o), .sda_oe_b_o(sda_oe_b_o),
	.slave_mode_select_i(slave_mode_select_i), .start_irq_enable_i(start_irq_enable_i),
	.address_hold_enable_i(address_hold_enable_i), .data_hold_enable_i(data_hold_enable_i),
	.rx_load_o(rx_load_o), .port_irq_o(port_irq_o), .ack_time_flag_o(ack_time_flag_o),
	.start_seen_o(start_seen_o), .stop_seen_o(stop_seen_o), .bus_idle_o(bus_idle_o)
);
`default_nettype wire

// ---- i2cs_master.sv ----
// Bus master model driving the two-wire lines open-drain
`timescale 1ns/1ps
`default_nettype none
module i2cs_master
(
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	int t_lo = 320;
	initial
	begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end
	task automatic bitx(input logic b, output logic r);
		#(t_lo / 2) sda_o = b;
		#(t_lo / 2) scl_o = 1'h1;
		wait (scl_i);
		#160 r = sda_i;
		scl_o = 1'h0;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'h1, ack);
	endtask
	task automatic recv(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'h1, d[i]);
		bitx(ack, r);
	endtask
	task automatic start();
		#(t_lo / 2) sda_o = 1'h1;
		#(t_lo / 2) scl_o = 1'h1;
		wait (scl_i);
		#160 sda_o = 1'h0;
		#160 scl_o = 1'h0;
	endtask
	task automatic stop();
		#(t_lo / 2) sda_o = 1'h0;
		#(t_lo / 2) scl_o = 1'h1;
		wait (scl_i);
		#160 sda_o = 1'h1;
		#320;
	endtask
	// Data dip with clock held high
	task automatic glitch();
		#160 sda_o = 1'h0;
		#160 sda_o = 1'h1;
		#320;
	endtask
endmodule // i2cs_master
`default_nettype wire

// ---- i2c_slave_bus_conditions_tb_top.sv ----
// Self-checking bench for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module i2c_slave_bus_conditions_tb_top;
	logic clk_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic [1:0] mode = 2'h0;
	logic [7:0] own = 8'h5a;
	logic [7:0] txd = 8'ha6;
	logic lhs = 1'h0, sie = 1'h0, ahe = 1'h0, dhe = 1'h0, arv = 1'h0, rel = 1'h0;
	logic bff = 1'h0, rof = 1'h0;
	wire m_scl, m_sda, scl_oe_b, sda_oe_b;
	wire scl = m_scl & scl_oe_b;
	wire sda = m_sda & sda_oe_b;
	wire [7:0] rbuf;
	wire ld, irq, ack_res, ack_tim, st, sp, rnw, coll, idle;
	int err_count = 0, n_compared = 0, cyc = 0;
	int n_st = 0, n_sp = 0, n_irq = 0, n_at = 0, n_coll = 0;
	logic a;
	logic [7:0] d;
	int k;
	int j;
	i2cs_core i2cs_core_i
	(
		.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
		.scl_oe_b_o(scl_oe_b), .sda_oe_b_o(sda_oe_b), .scl_o(), .sda_o(),
		.slave_mode_select_i(mode), .own_address_i(own), .address_mask_i(8'hff),
		.long_hold_select_i(lhs), .start_irq_enable_i(sie), .stop_irq_enable_i(1'h0),
		.address_hold_enable_i(ahe), .data_hold_enable_i(dhe),
		.ack_response_value_i(arv), .clock_release_i(rel), .tx_data_i(txd),
		.buffer_full_flag_i(bff), .receive_overflow_flag_i(rof), .receive_buffer_o(rbuf),
		.rx_load_o(ld), .port_irq_o(irq), .ack_result_bit_o(ack_res),
		.ack_time_flag_o(ack_tim), .start_seen_o(st), .stop_seen_o(sp),
		.read_not_write_o(rnw), .collision_o(coll), .bus_idle_o(idle)
	);
	i2cs_master i2cs_master_i (.scl_i(scl), .sda_i(sda), .scl_o(m_scl), .sda_o(m_sda));
	always #20 clk_i = !clk_i;
	// Release any stretch promptly
	always @(posedge clk_i)
		rel <= #1 !scl_oe_b & !rel;
	always @(posedge clk_i)
	begin
		cyc++;
		if (st === 1'h1) n_st++;
		if (sp === 1'h1) n_sp++;
		if (irq === 1'h1) n_irq++;
		if (ack_tim === 1'h1) n_at++;
		if (coll === 1'h1) n_coll++;
		if (cyc == 20000)
		begin
			err_count++;
			final_report();
		end
	end
	task automatic final_report();
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_write(input logic [1:0] m, input logic s);
		@(posedge clk_i) #1 {mode, sie} = {m, s};
		k = n_st;
		i2cs_master_i.start();
		`CHK("start", k + 1, n_st)
		i2cs_master_i.send(8'h5a, a);
		`CHK("addr_ack", 1'h0, a)
		`CHK("rnw", 1'h0, rnw)
		i2cs_master_i.send(8'h4d, a);
		`CHK("data", 8'h4d, rbuf)
		k = n_sp;
		i2cs_master_i.stop();
		`CHK("stop", k + 1, n_sp)
	endtask
	task automatic t_miss();
		@(posedge clk_i) #1 {mode, sie} = 3'h0;
		i2cs_master_i.start();
		k = n_irq;
		i2cs_master_i.send(8'h20, a);
		`CHK("miss_nack", 1'h1, a)
		`CHK("miss_irq", k, n_irq)
		i2cs_master_i.stop();
	endtask
	task automatic t_read();
		i2cs_master_i.start();
		i2cs_master_i.send(8'h5b, a);
		`CHK("rd_ack", 1'h0, a)
		`CHK("rnw_rd", 1'h1, rnw)
		i2cs_master_i.recv(d, 1'h0);
		`CHK("rd_data", 8'ha6, d)
		`CHK("ack_res0", 1'h0, ack_res)
		i2cs_master_i.recv(d, 1'h1);
		`CHK("ack_res1", 1'h1, ack_res)
		i2cs_master_i.stop();
	endtask
	task automatic t_full();
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_i) #1 {bff, rof} = i ? 2'h1 : 2'h2;
			i2cs_master_i.start();
			i2cs_master_i.send(8'h5a, a);
			`CHK("full_nack", 1'h1, a)
			i2cs_master_i.stop();
		end
		@(posedge clk_i) #1 {bff, rof} = 2'h0;
	endtask
	task automatic t_hold();
		@(posedge clk_i) #1 {ahe, dhe, lhs, arv} = 4'he;
		i2cs_master_i.t_lo = 640;
		k = n_at;
		i2cs_master_i.start();
		i2cs_master_i.send(8'h5a, a);
		`CHK("hold_ack", 1'h0, a)
		`CHK("ack_time", 1'h1, n_at > k)
		@(posedge clk_i) #1 arv = 1'h1;
		i2cs_master_i.send(8'h11, a);
		`CHK("hold_nack", 1'h1, a)
		i2cs_master_i.stop();
		i2cs_master_i.t_lo = 320;
		@(posedge clk_i) #1 {ahe, dhe, lhs, arv} = 4'h0;
	endtask
	task automatic t_ten();
		@(posedge clk_i) #1 {mode, own} = {2'h3, 8'h02};
		i2cs_master_i.start();
		i2cs_master_i.send(8'hf2, a);
		`CHK("hi_ack", 1'h0, a)
		@(posedge clk_i) #1 own = 8'h37;
		i2cs_master_i.send(8'h37, a);
		`CHK("lo_ack", 1'h0, a)
		@(posedge clk_i) #1 own = 8'h02;
		k = n_irq;
		i2cs_master_i.start();
		`CHK("rs_irq", 1'h1, n_irq > k)
		i2cs_master_i.send(8'hf3, a);
		`CHK("rd_hi_ack", 1'h0, a)
		`CHK("rnw10", 1'h1, rnw)
		i2cs_master_i.recv(d, 1'h1);
		`CHK("rd10", 8'ha6, d)
		i2cs_master_i.stop();
		@(posedge clk_i) #1 {mode, own} = {2'h0, 8'h5a};
	endtask
	task automatic t_glitch_coll();
		k = n_st;
		j = n_sp;
		i2cs_master_i.glitch();
		`CHK("gl_start", k + 1, n_st)
		`CHK("gl_stop", j, n_sp)
		@(posedge clk_i) #1 txd = 8'hff;
		k = n_coll;
		i2cs_master_i.start();
		i2cs_master_i.send(8'h5b, a);
		i2cs_master_i.bitx(1'h0, a);
		`CHK("coll", 1'h1, n_coll > k)
		i2cs_master_i.stop();
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		#1 rst_b_i = 1'h1;
		repeat (3) @(posedge clk_i);
		`CHK("sda_rel", 1'h1, sda_oe_b)
		`CHK("scl_rel", 1'h1, scl_oe_b)
		`CHK("idle", 1'h1, idle)
		for (int i = 0; i < 4; i++)
			t_write(i[1] ? 2'h2 : 2'h0, i[0]);
		t_miss();
		t_read();
		t_full();
		t_hold();
		t_ten();
		t_glitch_coll();
		final_report();
	end
endmodule // i2c_slave_bus_conditions_tb_top
`default_nettype wire
